// file: rtl/srhp_port.sv
// serial register host port: i2c or spi target in front of the register file
// Function
// - one host port only, i2c or spi, fixed by the programmed configuration bit.
// - i2c address from two three-level pins, six combinations 0x50 to 0x5A.
// - i2c target works at bus rates up to 400 kbit/s.
// - start, address and write bit; acknowledge a matching address.
// - acknowledge the register address byte and every written data byte.
// - each further written byte goes to the next register.
// - read: write address, repeated start, read address; ack then send byte.
// - master ack fetches the next register; nack then stop ends.
// - target only, never drives the bus unless addressed.
// - spi mode 2, clock idles high, data sampled on falling edge.
// - frame starts with select low; first eight clocks carry address and r/w.
// - r/w bit high means read, low means write.
// - spi write: each following eight clocks write the next register.
// - spi read: shift register out after command, consecutive registers follow.
`timescale 1ns/10ps
`default_nettype none
module srhp_port
    import srhp_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // programmed interface choice, high selects spi
    input wire logic i_otp_spi_sel,
    // three-level pins as level codes, pin b also data out
    input wire logic [1:0] i_addr_sel_a_or_chip_sel,
    input wire logic [1:0] i_addr_sel_b_or_data_out,
    output logic o_addr_sel_b_or_data_out,
    output logic o_addr_sel_b_or_data_out_oe,
    // clock pin, open drain in i2c
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    // data pin, open drain in i2c, data in for spi
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // register write stream
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [6:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    // register read fetch, data one cycle after request
    output logic o_rd_req,
    output logic [6:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    // status
    output logic o_spi_sel,
    output logic o_spi_overrun
);
    // ------------------------------------------------------------
    // synchronisers and edge detection
    // ------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sync1_r <= {i_addr_sel_a_or_chip_sel, i_addr_sel_b_or_data_out, i_scl, i_sda};
            sync2_r <= sync1_r;
            scl_d_r <= sync2_r[1];
            sda_d_r <= sync2_r[0];
        end
    end

    wire [1:0] pa = sync2_r[5:4];
    wire [1:0] pb = sync2_r[3:2];
    wire scl_s = sync2_r[1];
    wire sda_s = sync2_r[0];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire i2c_start = scl_s & scl_d_r & ~sda_s & sda_d_r;
    wire i2c_stop = scl_s & scl_d_r & sda_s & ~sda_d_r;
    wire cs_n = (pa != LV_LOW);

    // ------------------------------------------------------------
    // interface choice and address
    // ------------------------------------------------------------
    logic spi_mode_r;
    logic cfg_done_r;
    logic zero_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            spi_mode_r <= 1'b0;
            cfg_done_r <= 1'b0;
            zero_r <= 1'b0;
        end else if (!cfg_done_r) begin
            spi_mode_r <= i_otp_spi_sel;
            cfg_done_r <= 1'b1;
        end
    end

    wire i2c_act = cfg_done_r & ~spi_mode_r;
    wire spi_act = cfg_done_r & spi_mode_r;

    function automatic logic [7:0] addr_map(input logic [1:0] a, input logic [1:0] b);
        logic [7:0] r;
        r = 8'h00;
        if (a == LV_LOW && b == LV_LOW) r = {1'b1, TADDR_LL};
        else if (a == LV_SUPPLY && b == LV_SUPPLY) r = {1'b1, TADDR_SS};
        else if (a == LV_FLOAT && b == LV_LOW) r = {1'b1, TADDR_FL};
        else if (a == LV_LOW && b == LV_SUPPLY) r = {1'b1, TADDR_LS};
        else if (a == LV_SUPPLY && b == LV_LOW) r = {1'b1, TADDR_SL};
        else if (a == LV_FLOAT && b == LV_SUPPLY) r = {1'b1, TADDR_FS};
        return r;
    endfunction : addr_map

    wire [7:0] dev_map = addr_map(pa, pb);
    wire dev_ok = dev_map[7];
    wire [6:0] dev_addr = dev_map[6:0];

    // ------------------------------------------------------------
    // i2c target
    // ------------------------------------------------------------
    srhp_i2c_e ist_r;
    logic [3:0] icnt_r;
    logic [7:0] ish_r;
    logic irw_r;
    logic first_r;
    logic iack_r;
    logic [7:0] tx_r;
    logic [6:0] ptr_r;
    logic buf_rdy;

    wire i_bdone = scl_fall & (icnt_r == BYTE_BITS);
    wire addr_hit = dev_ok & (ish_r[7:1] == dev_addr);
    wire i_ptr_ld = (ist_r == I2C_RX) & i_bdone & first_r;
    wire i_push = (ist_r == I2C_HOLD) & buf_rdy;
    wire i_fetch0 = (ist_r == I2C_AACK) & scl_rise & irw_r;
    wire i_fetch1 = (ist_r == I2C_MACK) & scl_rise & ~sda_s;
    wire i_tx_shift = scl_fall & (((ist_r == I2C_AACK) & irw_r)
                      | ((ist_r == I2C_TX) & (icnt_r != BYTE_BITS))
                      | ((ist_r == I2C_MACK) & iack_r));

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !i2c_act) begin
            ist_r <= I2C_IDLE;
            icnt_r <= I2C_CNT_RST;
            ish_r <= BYTE_RST;
            irw_r <= 1'b0;
            first_r <= 1'b0;
            iack_r <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else if (i2c_stop) begin
            ist_r <= I2C_IDLE;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else if (i2c_start) begin
            ist_r <= I2C_ADDR;
            icnt_r <= I2C_CNT_RST;
            o_sda_oe <= 1'b0;
        end else begin
            if (scl_rise) begin
                icnt_r <= icnt_r + 4'h1;
                iack_r <= ~sda_s;
            end
            if (scl_rise && (ist_r == I2C_ADDR || ist_r == I2C_RX)) begin
                ish_r <= {ish_r[6:0], sda_s};
            end
            case (ist_r)
                I2C_ADDR: begin
                    if (i_bdone && addr_hit) begin
                        ist_r <= I2C_AACK;
                        irw_r <= ish_r[0];
                        o_sda_oe <= 1'b1;
                    end else if (i_bdone) begin
                        ist_r <= I2C_IDLE;
                    end
                end
                I2C_AACK: begin
                    if (scl_fall) begin
                        icnt_r <= I2C_CNT_RST;
                        first_r <= ~irw_r;
                        ist_r <= irw_r ? I2C_TX : I2C_RX;
                        o_sda_oe <= irw_r & ~tx_r[7];
                    end
                end
                I2C_RX: begin
                    if (i_bdone && first_r) begin
                        ist_r <= I2C_RACK;
                        first_r <= 1'b0;
                        o_sda_oe <= 1'b1;
                    end else if (i_bdone) begin
                        ist_r <= I2C_HOLD;
                    end
                end
                I2C_HOLD: begin
                    if (buf_rdy) begin
                        ist_r <= I2C_RACK;
                        o_sda_oe <= 1'b1;
                        o_scl_oe <= 1'b0;
                    end else begin
                        o_sda_oe <= 1'b1;
                        o_scl_oe <= 1'b1;
                    end
                end
                I2C_RACK: begin
                    if (scl_fall) begin
                        ist_r <= I2C_RX;
                        icnt_r <= I2C_CNT_RST;
                        o_sda_oe <= 1'b0;
                    end
                end
                I2C_TX: begin
                    if (scl_fall && icnt_r == BYTE_BITS) begin
                        ist_r <= I2C_MACK;
                        o_sda_oe <= 1'b0;
                    end else if (scl_fall) begin
                        o_sda_oe <= ~tx_r[7];
                    end
                end
                I2C_MACK: begin
                    if (scl_fall) begin
                        icnt_r <= I2C_CNT_RST;
                        ist_r <= iack_r ? I2C_TX : I2C_IDLE;
                        o_sda_oe <= iack_r & ~tx_r[7];
                    end
                end
                default: begin
                    ist_r <= I2C_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // spi target, mode 2
    // ------------------------------------------------------------
    logic [2:0] scnt_r;
    logic [7:0] ssh_r;
    logic scmd_r;
    logic srw_r;

    wire [7:0] s_byte = {ssh_r[6:0], sda_s};
    wire s_bdone = spi_act & ~cs_n & scl_fall & (scnt_r == SPI_LAST_BIT);
    wire s_cmd = s_bdone & ~scmd_r;
    wire s_wr = s_bdone & scmd_r & ~srw_r;
    wire s_rd = s_bdone & scmd_r & srw_r;
    wire s_tx_shift = spi_act & ~cs_n & scl_rise & scmd_r & srw_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst || !spi_act || cs_n) begin
            scnt_r <= SPI_CNT_RST;
            ssh_r <= BYTE_RST;
            scmd_r <= 1'b0;
            srw_r <= 1'b0;
            o_addr_sel_b_or_data_out <= 1'b0;
            o_addr_sel_b_or_data_out_oe <= 1'b0;
        end else begin
            if (scl_fall) begin
                ssh_r <= s_byte;
                scnt_r <= scnt_r + 3'h1;
            end
            if (s_cmd) begin
                scmd_r <= 1'b1;
                srw_r <= s_byte[0];
            end
            if (s_tx_shift) begin
                o_addr_sel_b_or_data_out <= tx_r[7];
                o_addr_sel_b_or_data_out_oe <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // shared pointer, fetch and write path
    // ------------------------------------------------------------
    logic rd_pend_r;
    logic [14:0] wr_word;

    wire ptr_ld = i_ptr_ld | s_cmd;
    wire [6:0] ptr_ld_v = spi_mode_r ? s_byte[7:1] : ish_r[6:0];
    wire ptr_inc = i_push | i_fetch1 | s_wr | s_rd;
    wire fetch = i_fetch0 | i_fetch1 | (s_cmd & s_byte[0]) | s_rd;
    wire [6:0] fetch_addr = (i_fetch0 | s_cmd) ? ptr_ld_v : ptr_r + PTR_STEP;
    wire [6:0] fetch_base = i_fetch0 ? ptr_r : fetch_addr;
    wire push = i_push | (s_wr & buf_rdy);
    wire [7:0] push_byte = spi_mode_r ? s_byte : ish_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ptr_r <= PTR_RST;
        end else if (ptr_ld) begin
            ptr_r <= ptr_ld_v;
        end else if (ptr_inc) begin
            ptr_r <= ptr_r + PTR_STEP;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_rd_req <= 1'b0;
            o_rd_addr <= PTR_RST;
            rd_pend_r <= 1'b0;
            tx_r <= BYTE_RST;
            o_spi_overrun <= 1'b0;
        end else begin
            o_rd_req <= fetch;
            rd_pend_r <= o_rd_req;
            if (fetch) begin
                o_rd_addr <= fetch_base;
            end
            if (rd_pend_r) begin
                tx_r <= i_rd_data;
            end else if (i_tx_shift || s_tx_shift) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (s_wr && !buf_rdy) begin
                o_spi_overrun <= 1'b1;
            end
        end
    end

    srhp_buf2 #(
        .W(BUF_W)
    ) u_wbuf (
        .i_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_valid(push),
        .o_ready(buf_rdy),
        .i_data({ptr_r, push_byte}),
        .o_valid(o_wr_valid),
        .i_ready(i_wr_ready),
        .o_data(wr_word)
    );

    assign o_wr_addr = wr_word[14:8];
    assign o_wr_data = wr_word[7:0];
    assign o_sda = zero_r;
    assign o_scl = zero_r;
    assign o_spi_sel = spi_mode_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    a_mode_fixed: assert property (cfg_done_r |=> $stable(spi_mode_r))
        else $error("interface choice changed after configuration");
    a_one_port: assert property (spi_mode_r |-> !o_sda_oe && !o_scl_oe)
        else $error("i2c pins driven in spi mode");
    a_addr_table: assert property ((pa == LV_FLOAT && pb == LV_SUPPLY) |-> dev_addr == 7'h5A)
        else $error("float and supply do not give the last address");
    a_addr_ack: assert property (ist_r == I2C_ADDR && i_bdone && addr_hit
        |=> o_sda_oe && ist_r == I2C_AACK)
        else $error("matching address not acknowledged");
    a_data_ack: assert property (ist_r == I2C_HOLD && buf_rdy |=> o_sda_oe && o_wr_valid)
        else $error("data byte not acknowledged and queued");
    a_wr_incr: assert property (i_push |=> ptr_r == $past(ptr_r) + PTR_STEP)
        else $error("pointer did not step after a written byte");
    a_rd_fetch: assert property (i_fetch0 |=> o_rd_req && o_rd_addr == $past(ptr_r))
        else $error("read did not fetch the addressed register");
    a_rd_next: assert property (ist_r == I2C_MACK && scl_rise && !sda_s
        |=> o_rd_req ##2 tx_r == $past(i_rd_data))
        else $error("master ack did not load the next byte");
    a_nack_end: assert property (ist_r == I2C_MACK && scl_fall && !iack_r && !i2c_start
        |=> ist_r == I2C_IDLE && !o_sda_oe)
        else $error("nack did not end the read");
    a_idle_quiet: assert property (ist_r == I2C_IDLE |-> !o_sda_oe && !o_scl_oe)
        else $error("data line driven while idle");
    a_spi_cmd: assert property (s_cmd && s_byte[0] |=> o_rd_req && o_rd_addr == $past(s_byte[7:1]))
        else $error("spi read command did not fetch");
    a_spi_wr: assert property (s_wr && buf_rdy |-> push ##1 ptr_r == $past(ptr_r) + PTR_STEP)
        else $error("spi data byte not written");
    a_cs_release: assert property (cs_n |=> !o_addr_sel_b_or_data_out_oe && scnt_r == SPI_CNT_RST)
        else $error("data out not released on deselect");
    a_nomatch: assert property (ist_r == I2C_ADDR && i_bdone && !addr_hit
        |=> ist_r == I2C_IDLE && !o_sda_oe)
        else $error("foreign address not ignored");

    c_i2c_write: cover property (i_push);
    c_i2c_read_two: cover property (i_fetch1);
    c_i2c_stretch: cover property (o_scl_oe);
    c_spi_write: cover property (s_wr && buf_rdy);
    c_spi_read: cover property (s_tx_shift && scnt_r == SPI_CNT_RST);
endmodule : srhp_port
`default_nettype wire

// file: rtl/srhp_pkg.sv
// serial register host port: pin codes, target addresses, counts, states
package srhp_pkg;
    // three-level pin codes from the level detector
    localparam logic [1:0] LV_LOW = 2'h0;
    localparam logic [1:0] LV_FLOAT = 2'h1;
    localparam logic [1:0] LV_SUPPLY = 2'h2;
    // i2c target addresses, first letter pin a, second pin b
    localparam logic [6:0] TADDR_LL = 7'h50;
    localparam logic [6:0] TADDR_SS = 7'h52;
    localparam logic [6:0] TADDR_FL = 7'h54;
    localparam logic [6:0] TADDR_LS = 7'h56;
    localparam logic [6:0] TADDR_SL = 7'h58;
    localparam logic [6:0] TADDR_FS = 7'h5A;
    // widths and counts
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BUF_W = ADDR_W + DATA_W;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam logic [6:0] PTR_STEP = 7'h01;
    // values after reset
    localparam logic [5:0] SYNC_RST = 6'h2B;
    localparam logic [3:0] I2C_CNT_RST = 4'h0;
    localparam logic [2:0] SPI_CNT_RST = 3'h0;
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // i2c target states
    typedef enum logic [2:0] {
        I2C_IDLE = 3'h0,
        I2C_ADDR = 3'h1,
        I2C_AACK = 3'h2,
        I2C_RX = 3'h3,
        I2C_RACK = 3'h4,
        I2C_HOLD = 3'h5,
        I2C_TX = 3'h6,
        I2C_MACK = 3'h7
    } srhp_i2c_e;
endpackage : srhp_pkg

// file: rtl/srhp_buf2.sv
// two-entry write buffer with registered outputs
`timescale 1ns/10ps
`default_nettype none
module srhp_buf2
    import srhp_pkg::*;
#(
    parameter int W = BUF_W
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    // drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    logic [W-1:0] spare_r;
    logic spare_v_r;
    wire pop = o_valid & i_ready;
    wire push = i_valid & o_ready;

    assign o_ready = ~spare_v_r;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_valid <= 1'b0;
            spare_v_r <= 1'b0;
            o_data <= '0;
            spare_r <= '0;
        end else if (pop && spare_v_r) begin
            o_data <= spare_r;
            spare_v_r <= 1'b0;
        end else if (pop || !o_valid) begin
            o_valid <= push;
            if (push) begin
                o_data <= i_data;
            end
        end else if (push) begin
            spare_r <= i_data;
            spare_v_r <= 1'b1;
        end
    end
endmodule : srhp_buf2
`default_nettype wire

// file: verification/srhp_host.sv
// host master model for the i2c and spi links
`timescale 1ns/10ps
`default_nettype none
module srhp_host
    import srhp_pkg::*;
(
    // clock and wire levels
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_miso,
    // driven levels
    output var logic o_scl,
    output var logic o_sda,
    output var logic [1:0] o_cs
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_cs = LV_SUPPLY;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // ----------------
    // i2c, 400 ns bits
    // ----------------
    task automatic rise();
        int k;
        k = 0;
        o_scl <= 1'b1;
        tick(1);
        while (i_scl !== 1'b1 && k < 4000) begin
            k++;
            tick(1);
        end
    endtask : rise
    task automatic bit_io(input logic b, output logic r);
        o_sda <= b;
        tick(2);
        rise();
        tick(2);
        r = i_sda;
        o_scl <= 1'b0;
        tick(3);
    endtask : bit_io
    task automatic start();
        o_sda <= 1'b1;
        tick(2);
        rise();
        tick(2);
        o_sda <= 1'b0;
        tick(4);
        o_scl <= 1'b0;
        tick(3);
    endtask : start
    task automatic stop();
        o_sda <= 1'b0;
        tick(2);
        rise();
        tick(2);
        o_sda <= 1'b1;
        tick(4);
    endtask : stop
    task automatic xfer(input logic [8:0] t, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            bit_io(t[i], r[i]);
        end
    endtask : xfer
    // ----------------
    // spi mode 2
    // ----------------
    task automatic spi_sel(input logic on);
        tick(2);
        o_cs <= on ? LV_LOW : LV_SUPPLY;
        if (!on) begin
            o_sda <= ~o_sda;
        end
        tick(4);
    endtask : spi_sel
    task automatic spi_byte(input logic [7:0] d, input int n, output logic [7:0] r);
        for (int i = 7; i > 7 - n; i--) begin
            o_sda <= d[i];
            tick(4);
            r[i] = i_miso;
            o_scl <= 1'b0;
            tick(4);
            o_scl <= 1'b1;
        end
    endtask : spi_byte
endmodule : srhp_host
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the serial register host port
`timescale 1ns/10ps
`default_nettype none
module tb
    import srhp_pkg::*;
;
    logic clk, nrst, otp, wr_ready, h_scl, h_sda;
    logic [1:0] pa, pb, h_cs;
    logic scl_oe, sda_oe, o_scl_v, o_sda_v, miso, miso_oe, wr_valid, rd_req, spi_sel, ovr;
    logic [6:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data;
    logic [7:0] mem [128];
    logic [14:0] wq [$];
    int errors, n_tests, cyc;
    wire logic scl_w = ~(scl_oe & ~o_scl_v) & h_scl;
    wire logic sda_w = ~(sda_oe & ~o_sda_v) & h_sda;
    wire logic miso_w = miso_oe ? miso : ~miso;
    wire logic [1:0] pa_w = otp ? h_cs : pa;
    srhp_port dut_u (
        .i_ref_clk(clk), .i_nrst(nrst), .i_otp_spi_sel(otp),
        .i_addr_sel_a_or_chip_sel(pa_w), .i_addr_sel_b_or_data_out(pb),
        .o_addr_sel_b_or_data_out(miso), .o_addr_sel_b_or_data_out_oe(miso_oe),
        .i_scl(scl_w), .o_scl(o_scl_v), .o_scl_oe(scl_oe),
        .i_sda(sda_w), .o_sda(o_sda_v), .o_sda_oe(sda_oe),
        .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
        .o_spi_sel(spi_sel), .o_spi_overrun(ovr)
    );
    srhp_host host_u (
        .i_clk(clk), .i_scl(scl_w), .i_sda(sda_w), .i_miso(miso_w),
        .o_scl(h_scl), .o_sda(h_sda), .o_cs(h_cs)
    );
    always #25 clk = ~clk;
    // ----------------
    // register sink and timeout
    // ----------------
    always @(posedge clk) begin
        rd_data <= rd_req ? mem[rd_addr] : ~rd_data;
        if (wr_valid && wr_ready) begin
            wq.push_back({wr_addr, wr_data});
        end
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            close_out();
        end
    end
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc_wait
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
        logic [14:0] w;
        w = 'x;
        if (wq.size() > 0) begin
            w = wq.pop_front();
        end
        chk("write word", {1'b0, w}, {1'b0, a, d});
    endtask : chk_wr
    task automatic do_reset(input logic spi);
        nrst <= 1'b0;
        otp <= spi;
        cyc_wait(6);
        nrst <= 1'b1;
        cyc_wait(4);
        chk("port kind", 16'(spi_sel), 16'(spi));
    endtask : do_reset
    task automatic close_out();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    // ----------------
    // scenarios
    // ----------------
    task automatic t_i2c_addr();
        logic [8:0] r;
        logic [1:0] sa [6];
        logic [1:0] sb [6];
        logic [6:0] ad [6];
        sa = '{LV_LOW, LV_SUPPLY, LV_FLOAT, LV_LOW, LV_SUPPLY, LV_FLOAT};
        sb = '{LV_LOW, LV_SUPPLY, LV_LOW, LV_SUPPLY, LV_LOW, LV_SUPPLY};
        ad = '{7'h50, 7'h52, 7'h54, 7'h56, 7'h58, 7'h5A};
        for (int i = 0; i < 6; i++) begin
            pa <= sa[i];
            pb <= sb[i];
            cyc_wait(6);
            host_u.start();
            host_u.xfer({ad[i], 1'b0, 1'b1}, r);
            host_u.stop();
            chk("own address ack", 16'(r[0]), 16'h0000);
            host_u.start();
            host_u.xfer({ad[i] ^ 7'h02, 1'b0, 1'b1}, r);
            host_u.stop();
            chk("foreign address nack", 16'(r[0]), 16'h0001);
            chk("sda released", 16'(sda_oe), 16'h0000);
        end
        pa <= LV_FLOAT;
        pb <= LV_FLOAT;
        cyc_wait(6);
        host_u.start();
        host_u.xfer({7'h50, 1'b0, 1'b1}, r);
        host_u.stop();
        chk("undefined strap nack", 16'(r[0]), 16'h0001);
        pa <= LV_LOW;
        pb <= LV_LOW;
        cyc_wait(6);
    endtask : t_i2c_addr
    task automatic t_i2c_write();
        logic [8:0] r;
        logic acc;
        wr_ready <= 1'b0;
        host_u.start();
        host_u.xfer({7'h50, 1'b0, 1'b1}, r);
        acc = r[0];
        host_u.xfer({8'hFF, 1'b1}, r);
        acc |= r[0];
        host_u.xfer({8'h11, 1'b1}, r);
        acc |= r[0];
        host_u.xfer({8'h22, 1'b1}, r);
        acc |= r[0];
        fork
            host_u.xfer({8'h33, 1'b1}, r);
            begin
                cyc_wait(200);
                chk("clock stretched", 16'(scl_oe), 16'h0001);
                wr_ready <= 1'b1;
            end
        join
        acc |= r[0];
        host_u.stop();
        chk("write acks", 16'(acc), 16'h0000);
        chk_wr(7'h7F, 8'h11);
        chk_wr(7'h00, 8'h22);
        chk_wr(7'h01, 8'h33);
    endtask : t_i2c_write
    task automatic t_i2c_read();
        logic [8:0] r;
        logic acc;
        host_u.start();
        host_u.xfer({7'h50, 1'b0, 1'b1}, r);
        acc = r[0];
        host_u.xfer({8'h7F, 1'b1}, r);
        acc |= r[0];
        host_u.start();
        host_u.xfer({7'h50, 1'b1, 1'b1}, r);
        acc |= r[0];
        host_u.xfer({8'hFF, 1'b0}, r);
        chk("read byte 0", 16'(r[8:1]), 16'(mem[7'h7F]));
        host_u.xfer({8'hFF, 1'b1}, r);
        chk("read byte 1", 16'(r[8:1]), 16'(mem[7'h00]));
        host_u.stop();
        chk("read acks", 16'(acc), 16'h0000);
        chk("sda idle", 16'(sda_oe), 16'h0000);
    endtask : t_i2c_read
    task automatic t_spi_write();
        logic [7:0] r;
        host_u.spi_sel(1'b1);
        host_u.spi_byte({7'h20, 1'b0}, 8, r);
        host_u.spi_byte(8'h3C, 8, r);
        host_u.spi_byte(8'hC3, 8, r);
        host_u.spi_sel(1'b0);
        chk_wr(7'h20, 8'h3C);
        chk_wr(7'h21, 8'hC3);
    endtask : t_spi_write
    task automatic t_spi_read();
        logic [7:0] r;
        host_u.spi_sel(1'b1);
        host_u.spi_byte({7'h30, 1'b1}, 8, r);
        host_u.spi_byte(8'h00, 8, r);
        chk("spi read 0", 16'(r), 16'(mem[7'h30]));
        host_u.spi_byte(8'h00, 8, r);
        chk("spi read 1", 16'(r), 16'(mem[7'h31]));
        host_u.spi_byte(8'h00, 4, r);
        host_u.spi_sel(1'b0);
        chk("data out released", 16'(miso_oe), 16'h0000);
        host_u.spi_sel(1'b1);
        host_u.spi_byte({7'h40, 1'b0}, 8, r);
        host_u.spi_byte(8'h5A, 8, r);
        host_u.spi_sel(1'b0);
        chk_wr(7'h40, 8'h5A);
        chk("stray writes", 16'(wq.size()), 16'h0000);
    endtask : t_spi_read
    task automatic t_spi_overrun();
        logic [7:0] r;
        wr_ready <= 1'b0;
        host_u.spi_sel(1'b1);
        host_u.spi_byte({7'h50, 1'b0}, 8, r);
        host_u.spi_byte(8'h01, 8, r);
        host_u.spi_byte(8'h02, 8, r);
        host_u.spi_byte(8'h03, 8, r);
        host_u.spi_sel(1'b0);
        chk("overrun flag", 16'(ovr), 16'h0001);
        wr_ready <= 1'b1;
        cyc_wait(6);
        chk_wr(7'h50, 8'h01);
        chk_wr(7'h51, 8'h02);
        chk("dropped word", 16'(wq.size()), 16'h0000);
    endtask : t_spi_overrun
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        otp = 1'b0;
        pa = LV_LOW;
        pb = LV_LOW;
        wr_ready = 1'b1;
        errors = 0;
        n_tests = 0;
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
        do_reset(1'b0);
        t_i2c_addr();
        t_i2c_write();
        t_i2c_read();
        do_reset(1'b1);
        t_spi_write();
        t_spi_read();
        t_spi_overrun();
        close_out();
    end
endmodule : tb
`default_nettype wire
